// file: pkg/pecu_params.svh
`ifndef PECU_PARAMS_SVH
`define PECU_PARAMS_SVH

// Translation-miss families
`define PECU_EV_DTLB_MISS 8'h49
`define PECU_EV_DTLB_LOAD_MISS 8'h08
`define PECU_EV_ITLB_MISS 8'h85

// First-level data cache families
`define PECU_EV_DC_WRITEBACK 8'h28
`define PECU_EV_DC_LOAD 8'h40
`define PECU_EV_DC_STORE 8'h41
`define PECU_EV_DC_ALL_REF 8'h43

// Partial-address aliasing
`define PECU_EV_ALIAS 8'h07
`define PECU_UM_ALIAS 8'h01

// Front end
`define PECU_EV_SEQ_UOPS 8'hD1
`define PECU_EV_PIPE_CLEAR 8'hC3
`define PECU_EV_LOOP_STREAM 8'hA8

// Coherence-state positions within a unit mask
`define PECU_MESI_I 0
`define PECU_MESI_S 1
`define PECU_MESI_E 2
`define PECU_MESI_M 3

// All-reference unit mask positions
`define PECU_ALLREF_CACHEABLE 0
`define PECU_ALLREF_ANY 1

// Counters of the core that may see data cache events
`define PECU_L1D_COUNTERS 2

// Reset values
`define PECU_COUNT_RESET 1'b0
`define PECU_STATUS_RESET 1'b0

`endif

// file: pkg/pecu_pkg.sv
`default_nettype none
package pecu_pkg;

  typedef struct packed {
    logic enable;
    logic int_en;
    logic [1:0] thread;
    logic [7:0] cmask;
    logic [7:0] umask;
    logic [7:0] evsel;
  } pecu_core_cfg_t;

  typedef struct packed {
    logic enable;
    logic [3:0] evsel;
  } pecu_shared_cfg_t;

  typedef struct packed {
    logic [7:0] dtlb_miss;
    logic [7:0] dtlb_load_miss;
    logic [7:0] itlb_miss;
    logic [1:0] dc_all_ref;
    logic [3:0] dc_load_mesi;
    logic [3:0] dc_store_mesi;
    logic [3:0] dc_wb_mesi;
    logic low_bits_alias;
    logic [3:0] seq_uops;
    logic pipeline_clear;
    logic [3:0] loop_stream_uops;
  } pecu_core_events_t;

endpackage
`default_nettype wire

// file: logic/pecu_counter.sv
`timescale 1ns/100ps
`default_nettype none
`include "pecu_params.svh"

module pecu_counter #(
  parameter int W = 48,
  parameter int IW = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [W-1:0] load_value,
  input wire logic [IW-1:0] inc,
  output logic [W-1:0] count,
  output logic ovf
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic ovf_reg;
  logic ovf_next;
  logic [W:0] sum;

  always_comb begin
    sum = {1'b0, count_reg} + {{(W+1-IW){1'b0}}, inc};
    if (load) begin
      count_next = load_value;
      ovf_next = 1'b0;
    end else begin
      count_next = sum[W-1:0];
      // Carry out of the top bit is the wrap
      ovf_next = sum[W];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= {W{`PECU_COUNT_RESET}};
      ovf_reg <= `PECU_STATUS_RESET;
    end else if (ce) begin
      count_reg <= count_next;
      ovf_reg <= ovf_next;
    end
  end

  assign count = count_reg;
  assign ovf = ovf_reg;

endmodule

`default_nettype wire

// file: logic/pecu_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "pecu_params.svh"

// How it works
// - Code 49H counts all data translation misses
// - Code 08H counts load translation misses
// - Code 85H counts instruction translation misses
// - Unit mask picks translation-miss sub-event
// - Data cache events only on counters 0,1
// - Load/store refs split by coherence state
// - Writebacks counted, masked by second-level state
// - Code 07H mask 01H counts alias conflicts
// - D1H sequencer uops, C3H clear cycles
// - Loop buffer seen via count-mask threshold
// - Shared monitor: eight general, one fixed
// - Fixed counter counts unhalted shared cycles
// - Shared overflow raised through per-core requests
// - Core mask picks which cores get signalled
// - Core monitor interrupts the processor picked by thread
// - Shared monitor keeps no event source identity
module pecu_top #(
  parameter int NUM_CORE_CNT = 4,
  parameter int NUM_SH_CNT = 8,
  parameter int CNT_W = 48,
  parameter int SH_W = 48,
  parameter int NUM_LP = 2,
  parameter int NUM_CORES = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire pecu_pkg::pecu_core_cfg_t [3:0] core_cfg,
  input wire pecu_pkg::pecu_core_events_t core_events,
  input wire logic [3:0] core_wr,
  input wire logic [3:0] core_ovf_clr,
  input wire pecu_pkg::pecu_shared_cfg_t [7:0] shared_cfg,
  input wire logic fixed_enable,
  input wire logic [15:0] shared_events,
  input wire logic shared_clk_tick,
  input wire logic shared_halted,
  input wire logic [8:0] shared_wr,
  input wire logic [8:0] shared_ovf_clr,
  input wire logic [NUM_CORES-1:0] shared_core_mask,
  input wire logic [CNT_W-1:0] wr_data,
  output logic [3:0][CNT_W-1:0] core_count,
  output logic [8:0][SH_W-1:0] shared_count,
  output logic [3:0] core_ovf_status,
  output logic [8:0] shared_ovf_status,
  output logic [NUM_LP-1:0] monitor_overflow_interrupt,
  output logic [NUM_CORES-1:0] core_irq_request
);
  import pecu_pkg::*;

  // Raw per-cycle count for one core counter's selection.
  // Sub-event vectors are or-reduced after masking, so a
  // mask with several bits counts a cycle once.
  function automatic logic [3:0] core_raw(
    input pecu_core_cfg_t c,
    input pecu_core_events_t e,
    input logic l1d_ok
  );
    logic [3:0] r;
    r = 4'h0;
    case (c.evsel)
      `PECU_EV_DTLB_MISS: begin
        r = {3'h0, |(e.dtlb_miss & c.umask)};
      end
      `PECU_EV_DTLB_LOAD_MISS: begin
        r = {3'h0, |(e.dtlb_load_miss & c.umask)};
      end
      `PECU_EV_ITLB_MISS: begin
        r = {3'h0, |(e.itlb_miss & c.umask)};
      end
      `PECU_EV_DC_ALL_REF: begin
        if (l1d_ok) begin
          r = {3'h0, |(e.dc_all_ref & c.umask[1:0])};
        end
      end
      `PECU_EV_DC_LOAD: begin
        // Invalid-state position marks the misses
        if (l1d_ok) begin
          r = {3'h0, |(e.dc_load_mesi & c.umask[3:0])};
        end
      end
      `PECU_EV_DC_STORE: begin
        if (l1d_ok) begin
          r = {3'h0, |(e.dc_store_mesi & c.umask[3:0])};
        end
      end
      `PECU_EV_DC_WRITEBACK: begin
        // Mask is the state of the second-level copy
        if (l1d_ok) begin
          r = {3'h0, |(e.dc_wb_mesi & c.umask[3:0])};
        end
      end
      `PECU_EV_ALIAS: begin
        if (c.umask == `PECU_UM_ALIAS) begin
          r = {3'h0, e.low_bits_alias};
        end
      end
      `PECU_EV_SEQ_UOPS: begin
        r = e.seq_uops;
      end
      `PECU_EV_PIPE_CLEAR: begin
        r = {3'h0, e.pipeline_clear};
      end
      `PECU_EV_LOOP_STREAM: begin
        // Only meaningful with a count mask applied
        r = e.loop_stream_uops;
      end
      default: begin
        r = 4'h0;
      end
    endcase
    return r;
  endfunction

  // Count mask turns a multi-count signal into a threshold
  // cycle count; zero leaves the raw count untouched.
  function automatic logic [3:0] apply_cmask(
    input logic [7:0] cmask,
    input logic [3:0] raw
  );
    logic [3:0] v;
    v = raw;
    if (cmask != 8'h00) begin
      v = ({4'h0, raw} >= cmask) ? 4'h1 : 4'h0;
    end
    return v;
  endfunction

  // Core-side counters
  logic [3:0][3:0] core_inc;
  logic [3:0] core_ovf;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CORE_CNT; gi++) begin : g_core
      always_comb begin
        if (core_cfg[gi].enable) begin
          core_inc[gi] = apply_cmask(core_cfg[gi].cmask,
            core_raw(core_cfg[gi], core_events, gi < `PECU_L1D_COUNTERS));
        end else begin
          core_inc[gi] = 4'h0;
        end
      end

      pecu_counter #(
        .W(CNT_W),
        .IW(4)
      ) u_core_cnt (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .load(core_wr[gi]),
        .load_value(wr_data),
        .inc(core_inc[gi]),
        .count(core_count[gi]),
        .ovf(core_ovf[gi])
      );
    end
  endgenerate

  // Shared-subsystem counters: eight general plus the fixed one
  // at index 8.
  logic [8:0] sh_inc;
  logic [8:0] sh_ovf;

  generate
    for (gi = 0; gi < NUM_SH_CNT; gi++) begin : g_shared
      always_comb begin
        sh_inc[gi] = shared_cfg[gi].enable & shared_clk_tick &
          shared_events[shared_cfg[gi].evsel];
      end

      pecu_counter #(
        .W(SH_W),
        .IW(1)
      ) u_sh_cnt (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .load(shared_wr[gi]),
        .load_value(wr_data[SH_W-1:0]),
        .inc(sh_inc[gi]),
        .count(shared_count[gi]),
        .ovf(sh_ovf[gi])
      );
    end
  endgenerate

  // Shared clock arrives as a tick in this domain; halted
  // cycles are skipped.
  always_comb begin
    sh_inc[8] = fixed_enable & shared_clk_tick & ~shared_halted;
  end

  pecu_counter #(
    .W(SH_W),
    .IW(1)
  ) u_fixed_cnt (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(shared_wr[8]),
    .load_value(wr_data[SH_W-1:0]),
    .inc(sh_inc[8]),
    .count(shared_count[8]),
    .ovf(sh_ovf[8])
  );

  // Sticky overflow status; a wrap in the clearing cycle wins
  logic [3:0] core_ovf_status_reg;
  logic [3:0] core_ovf_status_next;
  logic [8:0] shared_ovf_status_reg;
  logic [8:0] shared_ovf_status_next;

  always_comb begin
    core_ovf_status_next = (core_ovf_status_reg & ~core_ovf_clr) | core_ovf;
    // Only which counter wrapped is kept, never who caused it
    shared_ovf_status_next = (shared_ovf_status_reg & ~shared_ovf_clr) | sh_ovf;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      core_ovf_status_reg <= {4{`PECU_STATUS_RESET}};
      shared_ovf_status_reg <= {9{`PECU_STATUS_RESET}};
    end else if (ce) begin
      core_ovf_status_reg <= core_ovf_status_next;
      shared_ovf_status_reg <= shared_ovf_status_next;
    end
  end

  assign core_ovf_status = core_ovf_status_reg;
  assign shared_ovf_status = shared_ovf_status_reg;

  // Interrupt requests: one-cycle pulses per overflow event
  logic [NUM_LP-1:0] lp_irq_reg;
  logic [NUM_LP-1:0] lp_irq_next;
  logic [NUM_CORES-1:0] core_irq_reg;
  logic [NUM_CORES-1:0] core_irq_next;

  always_comb begin
    lp_irq_next = '0;
    for (int i = 0; i < NUM_CORE_CNT; i++) begin
      for (int t = 0; t < NUM_LP; t++) begin
        if (core_ovf[i] && core_cfg[i].int_en &&
            core_cfg[i].thread == t[1:0]) begin
          lp_irq_next[t] = 1'b1;
        end
      end
    end
  end

  // No interrupt line of its own: the mask fans a wrap out as
  // requests to the cores' interrupt logic. Software should set
  // every core here when sampling.
  always_comb begin
    core_irq_next = '0;
    if (|sh_ovf) begin
      core_irq_next = shared_core_mask;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lp_irq_reg <= '0;
      core_irq_reg <= '0;
    end else if (ce) begin
      lp_irq_reg <= lp_irq_next;
      core_irq_reg <= core_irq_next;
    end
  end

  assign monitor_overflow_interrupt = lp_irq_reg;
  assign core_irq_request = core_irq_reg;

endmodule

`default_nettype wire

// file: sim/pecu_top_props.sv
`timescale 1ns/100ps
`default_nettype none
module pecu_top_props #(
  parameter int CNT_W = 48,
  parameter int SH_W = 48,
  parameter int NUM_LP = 2,
  parameter int NUM_CORES = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] core_wr,
  input wire logic [3:0] core_ovf_clr,
  input wire logic fixed_enable,
  input wire logic shared_clk_tick,
  input wire logic shared_halted,
  input wire logic [8:0] shared_wr,
  input wire logic [NUM_CORES-1:0] shared_core_mask,
  input wire logic [CNT_W-1:0] wr_data,
  input wire logic [3:0][CNT_W-1:0] core_count,
  input wire logic [8:0][SH_W-1:0] shared_count,
  input wire logic [3:0] core_ovf_status,
  input wire logic [8:0] shared_ovf_status,
  input wire logic [NUM_LP-1:0] monitor_overflow_interrupt,
  input wire logic [NUM_CORES-1:0] core_irq_request
);
  logic fx_ok;
  assign fx_ok = fixed_enable & shared_clk_tick & ~shared_halted;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  rst_clear_a: assert property (disable iff (1'b0) rst |=> core_ovf_status == 4'h0 && core_irq_request == '0)
    else $error("outputs not cleared by reset");
  freeze_a: assert property (!ce |=> core_count == $past(core_count) && shared_count == $past(shared_count))
    else $error("counts moved while frozen");
  load_a: assert property (ce && core_wr[0] |=> core_count[0] == $past(wr_data))
    else $error("load value lost");
  fixed_step_a: assert property (ce && !shared_wr[8] |=> shared_count[8] == SH_W'($past(shared_count[8]) + $past(fx_ok)))
    else $error("fixed counter step wrong");
  wrap_status_a: assert property (ce && !core_wr[0] && core_count[0] == '1 ##1 ce && core_count[0] == '0 |=> core_ovf_status[0])
    else $error("wrap did not flag");
  sticky_a: assert property (core_ovf_status[0] && !core_ovf_clr[0] |=> core_ovf_status[0])
    else $error("flag dropped without clear");
  shared_req_a: assert property (core_irq_request != '0 |-> core_irq_request == shared_core_mask && shared_ovf_status != 9'h000)
    else $error("core request not from mask");
  lp_req_a: assert property (monitor_overflow_interrupt != '0 |-> core_ovf_status != 4'h0)
    else $error("interrupt without overflow");
  core_req_c: cover property (core_irq_request != '0);
  lp_req_c: cover property (monitor_overflow_interrupt != '0);
  freeze_c: cover property (!ce ##1 ce);
endmodule
bind pecu_top pecu_top_props #(.CNT_W(CNT_W), .SH_W(SH_W), .NUM_LP(NUM_LP), .NUM_CORES(NUM_CORES)) chk (
  .clk, .rst, .ce, .core_wr, .core_ovf_clr, .fixed_enable, .shared_clk_tick, .shared_halted, .shared_wr,
  .shared_core_mask, .wr_data, .core_count, .shared_count, .core_ovf_status, .shared_ovf_status,
  .monitor_overflow_interrupt, .core_irq_request
);
`default_nettype wire

// file: sim/pecu_irq_sink.sv
`timescale 1ns/100ps
`default_nettype none
module pecu_irq_sink (
  input wire logic clk,
  input wire logic [1:0] lp_irq,
  input wire logic [3:0] core_irq,
  output logic [7:0] lp_hits,
  output logic [7:0] core_hits
);
  initial begin
    lp_hits = 8'h00;
    core_hits = 8'h00;
  end
  // Each processor takes one interrupt per pulse
  always @(posedge clk) begin
    lp_hits <= lp_hits + 8'($countones(lp_irq));
    core_hits <= core_hits + 8'($countones(core_irq));
  end
endmodule
`default_nettype wire

// file: sim/tb_pecu_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_pecu_top;
  import pecu_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  pecu_core_cfg_t [3:0] core_cfg = '0;
  pecu_core_events_t core_events = '0;
  pecu_core_events_t e;
  logic [3:0] core_wr = 4'h0;
  logic [3:0] core_ovf_clr = 4'h0;
  pecu_shared_cfg_t [7:0] shared_cfg = '0;
  logic fixed_enable = 1'b0;
  logic [15:0] shared_events = 16'h0000;
  logic shared_clk_tick = 1'b0;
  logic shared_halted = 1'b0;
  logic [8:0] shared_wr = 9'h000;
  logic [8:0] shared_ovf_clr = 9'h000;
  logic [3:0] shared_core_mask = 4'hF;
  logic [7:0] wr_data = 8'h00;
  logic [3:0][7:0] core_count;
  logic [8:0][7:0] shared_count;
  logic [3:0] core_ovf_status;
  logic [8:0] shared_ovf_status;
  logic [1:0] monitor_overflow_interrupt;
  logic [3:0] core_irq_request;
  logic [7:0] lp_hits;
  logic [7:0] core_hits;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  // Narrow counters so a wrap is one load away
  pecu_top #(.CNT_W(8), .SH_W(8)) dut (.clk, .rst, .ce, .core_cfg, .core_events, .core_wr, .core_ovf_clr,
    .shared_cfg, .fixed_enable, .shared_events, .shared_clk_tick, .shared_halted, .shared_wr, .shared_ovf_clr,
    .shared_core_mask, .wr_data, .core_count, .shared_count, .core_ovf_status, .shared_ovf_status,
    .monitor_overflow_interrupt, .core_irq_request);
  pecu_irq_sink sink (.clk(clk), .lp_irq(monitor_overflow_interrupt), .core_irq(core_irq_request),
    .lp_hits(lp_hits), .core_hits(core_hits));
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("wrong value at %0t ns: %s", $time, m);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Load counter k, apply e for one cycle, compare
  task automatic ev_case(input int k, input logic [7:0] es, input logic [7:0] um, input logic [7:0] cm,
                         input logic [7:0] lv, input logic [7:0] exp, input logic [1:0] th);
    @(negedge clk);
    core_cfg[k] = {1'b1, 1'b1, th, cm, um, es};
    core_wr[k] = 1'b1;
    wr_data = lv;
    @(negedge clk);
    core_wr = 4'h0;
    core_events = e;
    @(negedge clk);
    core_events = '0;
    chk(core_count[k] === exp, "core counter");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    e = '0;
    e.dtlb_miss = 8'h01;
    ev_case(0, 8'h49, 8'h01, 8'h00, 8'h00, 8'h01, 2'h1);
    ev_case(0, 8'h49, 8'h02, 8'h00, 8'h00, 8'h00, 2'h1);
    ev_case(0, 8'h08, 8'h01, 8'h00, 8'h00, 8'h00, 2'h1);
    e.dtlb_load_miss = 8'h04;
    ev_case(0, 8'h08, 8'h04, 8'h00, 8'h10, 8'h11, 2'h1);
    e = '0;
    e.itlb_miss = 8'h80;
    ev_case(3, 8'h85, 8'h80, 8'h00, 8'h00, 8'h01, 2'h1);
    e = '0;
    e.dc_load_mesi = 4'h1;
    ev_case(1, 8'h40, 8'h01, 8'h00, 8'h00, 8'h01, 2'h1);
    ev_case(2, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 2'h1);
    ev_case(1, 8'h40, 8'h08, 8'h00, 8'h00, 8'h00, 2'h1);
    e = '0;
    e.dc_all_ref = 2'h1;
    ev_case(0, 8'h43, 8'h01, 8'h00, 8'h00, 8'h01, 2'h1);
    ev_case(3, 8'h43, 8'h01, 8'h00, 8'h00, 8'h00, 2'h1);
    e = '0;
    e.dc_store_mesi = 4'h8;
    ev_case(1, 8'h41, 8'h08, 8'h00, 8'h00, 8'h01, 2'h1);
    e = '0;
    e.dc_wb_mesi = 4'h2;
    ev_case(0, 8'h28, 8'h02, 8'h00, 8'h00, 8'h01, 2'h1);
    ev_case(0, 8'h28, 8'h04, 8'h00, 8'h00, 8'h00, 2'h1);
    e = '0;
    e.low_bits_alias = 1'b1;
    ev_case(1, 8'h07, 8'h01, 8'h00, 8'h00, 8'h01, 2'h1);
    ev_case(1, 8'h07, 8'h02, 8'h00, 8'h00, 8'h00, 2'h1);
    e = '0;
    e.seq_uops = 4'h3;
    ev_case(0, 8'hD1, 8'h00, 8'h00, 8'h00, 8'h03, 2'h1);
    e.loop_stream_uops = 4'h4;
    ev_case(1, 8'hA8, 8'h00, 8'h03, 8'h00, 8'h01, 2'h1);
    e.loop_stream_uops = 4'h2;
    ev_case(1, 8'hA8, 8'h00, 8'h03, 8'h00, 8'h00, 2'h1);
    e = '0;
    e.pipeline_clear = 1'b1;
    ev_case(0, 8'hC3, 8'h00, 8'h00, 8'hFF, 8'h00, 2'h1);
    chk(core_ovf_status === 4'h0, "flag too early");
    @(negedge clk);
    chk(core_ovf_status === 4'h1 && monitor_overflow_interrupt === 2'b10, "core overflow");
    @(negedge clk);
    chk(monitor_overflow_interrupt === 2'b00 && lp_hits === 8'h01, "pulse length");
    ce = 1'b0;
    core_events = e;
    @(negedge clk);
    chk(core_count[0] === 8'h00, "frozen count");
    ce = 1'b1;
    core_events = '0;
    core_ovf_clr = 4'h1;
    @(negedge clk);
    core_ovf_clr = 4'h0;
    chk(core_ovf_status === 4'h0, "flag clear");
    // Wrap on another counter aimed at the other processor
    ev_case(1, 8'hC3, 8'h00, 8'h00, 8'hFF, 8'h00, 2'h0);
    @(negedge clk);
    chk(core_ovf_status === 4'h2 && monitor_overflow_interrupt === 2'b01, "second processor");
    @(negedge clk);
    chk(monitor_overflow_interrupt === 2'b00 && lp_hits === 8'h02, "second pulse");
    // Every event line up, but no code selected
    e = '1;
    ev_case(2, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 2'h1);
    shared_cfg[7] = {1'b1, 4'hF};
    fixed_enable = 1'b1;
    shared_wr = 9'h1FF;
    wr_data = 8'h00;
    @(negedge clk);
    shared_wr = 9'h000;
    shared_events = 16'h8000;
    shared_clk_tick = 1'b1;
    @(negedge clk);
    shared_events = 16'h0000;
    shared_halted = 1'b1;
    @(negedge clk);
    shared_clk_tick = 1'b0;
    shared_halted = 1'b0;
    chk(shared_count[7] === 8'h01 && shared_count[8] === 8'h01 && shared_count[6] === 8'h00, "shared");
    shared_wr = 9'h100;
    wr_data = 8'hFF;
    @(negedge clk);
    shared_wr = 9'h000;
    shared_clk_tick = 1'b1;
    @(negedge clk);
    shared_clk_tick = 1'b0;
    chk(shared_count[8] === 8'h00, "fixed wrap");
    @(negedge clk);
    chk(shared_ovf_status === 9'h100 && core_irq_request === 4'hF, "shared overflow");
    shared_ovf_clr = 9'h100;
    @(negedge clk);
    shared_ovf_clr = 9'h000;
    chk(shared_ovf_status === 9'h000 && core_hits === 8'h04, "shared clear");
    // Partial mask: only the chosen cores may be asked
    shared_core_mask = 4'h6;
    shared_wr = 9'h100;
    wr_data = 8'hFF;
    @(negedge clk);
    shared_wr = 9'h000;
    shared_clk_tick = 1'b1;
    @(negedge clk);
    shared_clk_tick = 1'b0;
    @(negedge clk);
    chk(shared_ovf_status === 9'h100 && core_irq_request === 4'h6, "masked request");
    @(negedge clk);
    chk(core_irq_request === 4'h0 && core_hits === 8'h06, "masked cores");
    shared_core_mask = 4'hF;
    report_and_stop();
  end
endmodule
`default_nettype wire
